// ===== rtl/imw_cfg_slice.v
// pin configuration, millisecond watchdog and interrupt mask slice
// assumes register accesses and status levels come from logic on core_clk_i
`timescale 1ns/100ps
`include "imw_map.vh"

module imw_cfg_slice #(
  parameter MS_CYCLES = `IMW_MS_CYCLES
) (
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  input  wire [15:0] reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output wire [7:0]  reg_rdata_o,
  input  wire        system_clock_source_locked_i,
  input  wire        system_clock_source_stable_i,
  input  wire        system_clock_source_cal_busy_i,
  input  wire [3:0]  ref_fault_i,
  input  wire [3:0]  ref_valid_i,
  output wire [4:0]  pin_dir_o,
  output wire [34:0] pin_func_o,
  output wire        wd_expired_o,
  output wire        wd_running_o,
  output wire [7:0]  sys_monitor_evt_o,
  output wire [7:0]  ref_ab_monitor_evt_o,
  output wire [7:0]  ref_cd_monitor_evt_o
);

  localparam NREG = 13;
  localparam integer PRE_LAST_I = MS_CYCLES - 1;
  localparam [14:0] PRE_LAST = PRE_LAST_I[14:0];
  localparam [3:0] IDX_WD_LO = 4'h8;
  localparam [3:0] IDX_WD_HI = 4'h9;
  localparam [3:0] IDX_SYS   = 4'ha;
  localparam [3:0] IDX_AB    = 4'hb;
  localparam [3:0] IDX_CD    = 4'hc;

  reg  [7:0]  buf_reg [0:NREG-1];
  reg  [7:0]  act_reg [0:NREG-1];
  reg  [7:0]  rdata_reg;
  reg         wd_run_reg;
  reg  [14:0] wd_pre_reg;
  reg  [15:0] wd_ms_reg;
  reg         wd_exp_reg;
  reg         lock_prev_reg;
  reg         stable_prev_reg;
  reg         cal_prev_reg;
  reg  [3:0]  fault_prev_reg;
  reg  [3:0]  valid_prev_reg;
  reg  [7:0]  sys_evt_reg;
  reg  [7:0]  ab_evt_reg;
  reg  [7:0]  cd_evt_reg;

  wire [15:0] rel_addr = reg_addr_i - `IMW_FIRST_OFF;
  wire [3:0]  idx      = rel_addr[3:0];
  wire        hit      = (reg_addr_i >= `IMW_FIRST_OFF) && (reg_addr_i <= `IMW_LAST_OFF);
  wire        buf_wr   = reg_wr_i && hit;
  wire        update   = reg_wr_i && (reg_addr_i == `IMW_UPDATE_OFF) && reg_wdata_i[`IMW_UPDATE_BIT];
  wire        wd_write = buf_wr && ((idx == IDX_WD_LO) || (idx == IDX_WD_HI));
  wire [15:0] wd_new   = {buf_reg[IDX_WD_HI], buf_reg[IDX_WD_LO]};
  wire [15:0] wd_per   = {act_reg[IDX_WD_HI], act_reg[IDX_WD_LO]};
  wire [15:0] wd_last  = wd_per - 16'h0001;

  // writable bits per buffered register
  function [7:0] wmask;
    input [3:0] i;
    begin
      case (i)
        4'h2, 4'h6, 4'h7: wmask = `IMW_RSVD_WMASK;
        IDX_SYS:          wmask = `IMW_SYS_WMASK;
        IDX_AB, IDX_CD:   wmask = `IMW_REF_WMASK;
        default:          wmask = `IMW_FULL_WMASK;
      endcase
    end
  endfunction

  integer k;

  // buffered and active register banks
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (k = 0; k < NREG; k = k + 1) begin
        buf_reg[k] <= `IMW_REG_RESET;
        act_reg[k] <= `IMW_REG_RESET;
      end
    end else begin
      if (buf_wr) begin
        buf_reg[idx] <= reg_wdata_i & wmask(idx);
      end
      if (update) begin
        for (k = 0; k < NREG; k = k + 1) begin
          act_reg[k] <= buf_reg[k];
        end
      end
    end
  end

  // read path; strobe register reads zero as it self-clears
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_i && hit) begin
      rdata_reg <= buf_reg[idx];
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // millisecond watchdog
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_run_reg <= 1'b0;
      wd_pre_reg <= 15'h0000;
      wd_ms_reg  <= 16'h0000;
      wd_exp_reg <= 1'b0;
    end else begin
      wd_exp_reg <= 1'b0;
      if (wd_write) begin
        wd_run_reg <= 1'b0;
      end else if (update) begin
        wd_run_reg <= (wd_new != 16'h0000);
        wd_pre_reg <= 15'h0000;
        wd_ms_reg  <= 16'h0000;
      end else if (wd_run_reg) begin
        if (wd_pre_reg == PRE_LAST) begin
          wd_pre_reg <= 15'h0000;
          if (wd_ms_reg == wd_last) begin
            wd_ms_reg  <= 16'h0000;
            wd_exp_reg <= 1'b1;
          end else begin
            wd_ms_reg <= wd_ms_reg + 16'h0001;
          end
        end else begin
          wd_pre_reg <= wd_pre_reg + 15'h0001;
        end
      end
    end
  end

  // transition detection of status levels
  wire [7:0] sys_evt;
  wire [3:0] f_rise = ref_fault_i & ~fault_prev_reg;
  wire [3:0] f_fall = ~ref_fault_i & fault_prev_reg;
  wire [3:0] v_rise = ref_valid_i & ~valid_prev_reg;

  assign sys_evt[`IMW_SYS_UNLOCK_BIT]  = lock_prev_reg & ~system_clock_source_locked_i;
  assign sys_evt[`IMW_SYS_STABLE_BIT]  = ~stable_prev_reg & system_clock_source_stable_i;
  assign sys_evt[`IMW_SYS_LOCK_BIT]    = ~lock_prev_reg & system_clock_source_locked_i;
  assign sys_evt[`IMW_SYS_CAL_END_BIT] = cal_prev_reg & ~system_clock_source_cal_busy_i;
  assign sys_evt[`IMW_SYS_CAL_GO_BIT]  = ~cal_prev_reg & system_clock_source_cal_busy_i;
  assign sys_evt[`IMW_SYS_WD_BIT]      = wd_exp_reg;
  assign sys_evt[1:0]                  = 2'b00;

  wire [7:0] ab_evt = {1'b0, v_rise[1], f_fall[1], f_rise[1],
                       1'b0, v_rise[0], f_fall[0], f_rise[0]};
  wire [7:0] cd_evt = {1'b0, v_rise[3], f_fall[3], f_rise[3],
                       1'b0, v_rise[2], f_fall[2], f_rise[2]};

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_prev_reg   <= 1'b0;
      stable_prev_reg <= 1'b0;
      cal_prev_reg    <= 1'b0;
      fault_prev_reg  <= 4'h0;
      valid_prev_reg  <= 4'h0;
      sys_evt_reg     <= 8'h00;
      ab_evt_reg      <= 8'h00;
      cd_evt_reg      <= 8'h00;
    end else begin
      lock_prev_reg   <= system_clock_source_locked_i;
      stable_prev_reg <= system_clock_source_stable_i;
      cal_prev_reg    <= system_clock_source_cal_busy_i;
      fault_prev_reg  <= ref_fault_i;
      valid_prev_reg  <= ref_valid_i;
      sys_evt_reg     <= sys_evt & act_reg[IDX_SYS];
      ab_evt_reg      <= ab_evt & act_reg[IDX_AB];
      cd_evt_reg      <= cd_evt & act_reg[IDX_CD];
    end
  end

  // pin configuration from active bank: two, three, five, six, seven
  assign pin_dir_o = {act_reg[5][`IMW_PIN_DIR_BIT], act_reg[4][`IMW_PIN_DIR_BIT],
                      act_reg[3][`IMW_PIN_DIR_BIT], act_reg[1][`IMW_PIN_DIR_BIT],
                      act_reg[0][`IMW_PIN_DIR_BIT]};
  assign pin_func_o = {act_reg[5][`IMW_PIN_FUNC_MSB:0], act_reg[4][`IMW_PIN_FUNC_MSB:0],
                       act_reg[3][`IMW_PIN_FUNC_MSB:0], act_reg[1][`IMW_PIN_FUNC_MSB:0],
                       act_reg[0][`IMW_PIN_FUNC_MSB:0]};

  assign reg_rdata_o          = rdata_reg;
  assign wd_expired_o         = wd_exp_reg;
  assign wd_running_o         = wd_run_reg;
  assign sys_monitor_evt_o    = sys_evt_reg;
  assign ref_ab_monitor_evt_o = ab_evt_reg;
  assign ref_cd_monitor_evt_o = cd_evt_reg;

endmodule

// ===== rtl/imw_map.vh
// constants for the pin configuration, watchdog and interrupt mask slice
// assumes a 20 MHz core clock and byte-wide register offsets
//
// Contract
// - bit 7 of each pin configuration register picks control input or status output
// - direction bit zero, the reset value, means input; one means output
// - bits 6:0 pick pin function; zero leaves pin high impedance, unassigned
// - watchdog period is 16 bits over low and high byte, in milliseconds
// - a watchdog period of zero disables the watchdog
// - any write to either period byte stops the watchdog at once
// - a stopped watchdog restarts only on the next update strobe write of one
// - update strobe copies buffered registers into active ones, then clears itself
// - each mask bit maps one-to-one onto an interrupt monitor bit
// - a monitor bit records its event only while its mask bit is one
// - all mask bits reset to zero, so no event is seen by default
// - system clock mask bits 7,6,5: unlock, stable, lock events
// - system clock mask bit 4 calibration ended, bit 3 calibration started
// - system clock mask bit 2 watchdog expiry; bits 1:0 reserved zero
// - inputs one and two: bits 0,1,2 and 4,5,6 fault, cleared, validated
// - inputs three and four use a second mask register, same layout
`ifndef IMW_MAP_VH
`define IMW_MAP_VH

`define IMW_UPDATE_OFF    16'h000f
`define IMW_FIRST_OFF     16'h0105
`define IMW_LAST_OFF      16'h0111
`define IMW_PIN_TWO_OFF   16'h0105
`define IMW_PIN_THREE_OFF 16'h0106
`define IMW_RSVD_A_OFF    16'h0107
`define IMW_PIN_FIVE_OFF  16'h0108
`define IMW_PIN_SIX_OFF   16'h0109
`define IMW_PIN_SEVEN_OFF 16'h010a
`define IMW_RSVD_B_OFF    16'h010b
`define IMW_RSVD_C_OFF    16'h010c
`define IMW_WD_LOW_OFF    16'h010d
`define IMW_WD_HIGH_OFF   16'h010e
`define IMW_SYS_MASK_OFF  16'h010f
`define IMW_REF_AB_OFF    16'h0110
`define IMW_REF_CD_OFF    16'h0111

`define IMW_UPDATE_BIT    0
`define IMW_PIN_DIR_BIT   7
`define IMW_PIN_FUNC_MSB  6
`define IMW_REG_RESET     8'h00
`define IMW_SYS_WMASK     8'hfc
`define IMW_REF_WMASK     8'h77
`define IMW_RSVD_WMASK    8'h00
`define IMW_FULL_WMASK    8'hff

`define IMW_SYS_UNLOCK_BIT 7
`define IMW_SYS_STABLE_BIT 6
`define IMW_SYS_LOCK_BIT   5
`define IMW_SYS_CAL_END_BIT 4
`define IMW_SYS_CAL_GO_BIT 3
`define IMW_SYS_WD_BIT     2

`define IMW_CLK_PERIOD_NS 50
`define IMW_MS_NS         1000000
`define IMW_MS_CYCLES     (`IMW_MS_NS / `IMW_CLK_PERIOD_NS)

`endif

// ===== sim/imw_cfg_monitor.sv
// assertions on the slice ports
// assumes bind onto every imw_cfg_slice instance
`timescale 1ns/100ps
module imw_cfg_monitor (
  input wire        core_clk_i,
  input wire        rst_n_i,
  input wire [15:0] reg_addr_i,
  input wire [7:0]  reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [7:0]  reg_rdata_o,
  input wire        system_clock_source_locked_i,
  input wire [3:0]  ref_fault_i,
  input wire [4:0]  pin_dir_o,
  input wire        wd_expired_o,
  input wire        wd_running_o,
  input wire [7:0]  sys_monitor_evt_o,
  input wire [7:0]  ref_ab_monitor_evt_o,
  input wire [7:0]  ref_cd_monitor_evt_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_wd_once; wd_expired_o |=> !wd_expired_o; endproperty
  a_wd_once: assert property (p_wd_once) else $error("expiry longer than one cycle");
  property p_wd_stop;
    reg_wr_i && (reg_addr_i == 16'h010d || reg_addr_i == 16'h010e) |=> !wd_running_o && !wd_expired_o;
  endproperty
  a_wd_stop: assert property (p_wd_stop) else $error("watchdog kept running");
  property p_wd_evt; sys_monitor_evt_o[2] |-> $past(wd_expired_o); endproperty
  a_wd_evt: assert property (p_wd_evt) else $error("expiry event without expiry");
  property p_rsvd;
    sys_monitor_evt_o[1:0] == 2'h0 && {ref_ab_monitor_evt_o[7], ref_ab_monitor_evt_o[3]} == 2'h0
      && {ref_cd_monitor_evt_o[7], ref_cd_monitor_evt_o[3]} == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved event bit set");
  property p_lock_rise; sys_monitor_evt_o[5] |-> $past(system_clock_source_locked_i) && !$past(system_clock_source_locked_i, 2); endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock event without rise");
  property p_lock_fall; sys_monitor_evt_o[7] |-> !$past(system_clock_source_locked_i) && $past(system_clock_source_locked_i, 2); endproperty
  a_lock_fall: assert property (p_lock_fall) else $error("unlock event without fall");
  property p_fault; ref_ab_monitor_evt_o[0] |-> $past(ref_fault_i[0]) && !$past(ref_fault_i[0], 2); endproperty
  a_fault: assert property (p_fault) else $error("fault event without rise");
  property p_pin_upd; $changed(pin_dir_o) |-> $past(reg_wr_i && reg_addr_i == 16'h000f && reg_wdata_i[0]); endproperty
  a_pin_upd: assert property (p_pin_upd) else $error("pin direction changed without update");
  c_wd: cover property (wd_expired_o);
  c_lock: cover property (sys_monitor_evt_o[5]);
  c_fault: cover property (ref_ab_monitor_evt_o[0]);
endmodule
bind imw_cfg_slice imw_cfg_monitor u_mon (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .system_clock_source_locked_i, .ref_fault_i, .pin_dir_o, .wd_expired_o, .wd_running_o, .sys_monitor_evt_o,
  .ref_ab_monitor_evt_o, .ref_cd_monitor_evt_o);

// ===== sim/imw_host_model.sv
// host side register access model
// assumes accesses begin after reset release
`timescale 1ns/100ps
module imw_host_model (
  input  wire        core_clk_i,
  output reg  [15:0] reg_addr_o = 16'h0000,
  output reg  [7:0]  reg_wdata_o = 8'h00,
  output reg         reg_wr_o = 1'b0,
  output reg         reg_rd_o = 1'b0
);
  task acc(input [15:0] a, input [7:0] d, input w);
    begin
      @(posedge core_clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= w;
      reg_rd_o    <= !w;
      @(posedge core_clk_i);
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
      // released bus shows inverted values
      reg_addr_o  <= ~a;
      reg_wdata_o <= ~d;
    end
  endtask
endmodule

// ===== sim/irq_mask_watchdog_pin_config_tb.sv
// self-checking bench for the configuration slice
// assumes host model and monitor compiled first
`timescale 1ns/100ps
module irq_mask_watchdog_pin_config_tb;
  localparam MS = 4;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         lck = 1'b0, stb = 1'b0, cal = 1'b0, rd_seen = 1'b0;
  reg  [3:0]  flt = 4'h0, vld = 4'h0;
  wire [15:0] addr;
  wire [7:0]  wdata, rdata, sys_e, ab_e, cd_e;
  wire        wr, rd, wd_exp, wd_run;
  wire [4:0]  dir;
  wire [34:0] func;
  reg  [7:0]  wv [0:12];
  reg  [7:0]  exp_q [$];
  reg  [10:0] cur = 11'h000, p1 = 11'h000, p2 = 11'h000;
  integer     mismatches = 0, check_count = 0, seed = 32'he94555bd, i, n, c, xc = 0;
  always #25 clk = ~clk;
  imw_host_model u_host (.core_clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
  imw_cfg_slice #(.MS_CYCLES(MS)) u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .system_clock_source_locked_i(lck), .system_clock_source_stable_i(stb),
    .system_clock_source_cal_busy_i(cal), .ref_fault_i(flt), .ref_valid_i(vld), .pin_dir_o(dir), .pin_func_o(func),
    .wd_expired_o(wd_exp), .wd_running_o(wd_run), .sys_monitor_evt_o(sys_e), .ref_ab_monitor_evt_o(ab_e),
    .ref_cd_monitor_evt_o(cd_e));
  task check(input [63:0] seen, input [63:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task rd_chk(input [15:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      u_host.acc(a, 8'h00, 1'b0);
    end
  endtask
  task wait_exp;
    begin
      c = 0;
      do begin
        @(negedge clk);
        c = c + 1;
      end while (wd_exp !== 1'b1 && c < 1000);
      if (c >= 1000) begin
        mismatches = mismatches + 1;
        disable main;
      end
    end
  endtask
  // expected masked events, all masks open, from old and new input levels
  function [23:0] evt_exp(input [10:0] o, input [10:0] w);
    reg [3:0] fr, ff, vr;
    begin
      fr = w[7:4] & ~o[7:4];
      ff = ~w[7:4] & o[7:4];
      vr = w[3:0] & ~o[3:0];
      evt_exp = {o[10] & ~w[10], ~o[9] & w[9], ~o[10] & w[10], o[8] & ~w[8], ~o[8] & w[8], 3'b000,
                 1'b0, vr[1], ff[1], fr[1], 1'b0, vr[0], ff[0], fr[0],
                 1'b0, vr[3], ff[3], fr[3], 1'b0, vr[2], ff[2], fr[2]};
    end
  endfunction
  function [7:0] rmask(input integer k);
    rmask = (k == 2 || k == 6 || k == 7) ? 8'h00 : (k == 10) ? 8'hfc : (k > 10) ? 8'h77 : 8'hff;
  endfunction
  always @(posedge clk) rd_seen <= rd;
  always @(posedge clk) if (wd_exp === 1'b1) xc <= xc + 1;
  always @(negedge clk) if (rd_seen) check(rdata, exp_q.pop_front());
  initial begin
    begin : main
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 13; i = i + 1) rd_chk(16'h0105 + i, 8'h00);
    check({dir, func, wd_run}, 41'h0);
    for (i = 0; i < 13; i = i + 1) begin
      wv[i] = (i == 8) ? 8'h03 : (i == 9) ? 8'h00 : $random(seed);
      u_host.acc(16'h0105 + i, wv[i], 1'b1);
    end
    for (i = 0; i < 13; i = i + 1) rd_chk(16'h0105 + i, wv[i] & rmask(i));
    rd_chk(16'h000f, 8'h00);
    rd_chk(16'h0200, 8'h00);
    check(dir, 5'h00);
    u_host.acc(16'h000f, 8'h01, 1'b1);
    @(negedge clk);
    check(dir, {wv[5][7], wv[4][7], wv[3][7], wv[1][7], wv[0][7]});
    check(func, {wv[5][6:0], wv[4][6:0], wv[3][6:0], wv[1][6:0], wv[0][6:0]});
    wait_exp;
    wait_exp;
    check(c, 3 * MS);
    u_host.acc(16'h010e, 8'h00, 1'b1);
    @(negedge clk);
    n = xc;
    repeat (40) @(negedge clk);
    check({wd_run, xc}, n);
    u_host.acc(16'h000f, 8'h01, 1'b1);
    @(negedge clk);
    check(wd_run, 1'b1);
    u_host.acc(16'h010d, 8'h00, 1'b1);
    u_host.acc(16'h000f, 8'h01, 1'b1);
    repeat (30) @(negedge clk);
    check({wd_run, wd_exp}, 2'h0);
    for (n = 0; n < 2; n = n + 1) begin
      for (i = 10; i < 13; i = i + 1) u_host.acc(16'h0105 + i, {8{n[0]}}, 1'b1);
      u_host.acc(16'h000f, 8'h01, 1'b1);
      for (i = 0; i < 60; i = i + 1) begin
        @(posedge clk) begin
          cur = $random(seed);
          {lck, stb, cal, flt, vld} <= cur;
        end
        @(negedge clk) begin
          if (n == 0) check({sys_e, ab_e, cd_e}, 24'h0);
          else if (i > 1) check({sys_e, ab_e, cd_e}, evt_exp(p2, p1));
          p2 = p1;
          p1 = cur;
        end
      end
    end
    @(posedge clk) {lck, stb, cal, flt, vld} <= 11'h000;
    repeat (3) @(posedge clk);
    lck <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(sys_e, 8'h20);
    @(negedge clk);
    check(sys_e, 8'h00);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(16'h010f, 8'h00);
    repeat (2) @(posedge clk);
    end
    conclude;
  end
endmodule
